//--- verilog/pft_defines.svh
// Purpose: Constants of the program flash table access block
// Assumes: Core clock of 200 MHz
// Notes: Offsets are register select codes on the special register port
`ifndef PFT_DEFINES_SVH
`define PFT_DEFINES_SVH

// Special register select codes
`define PFT_SEL_PTR_LOW 3'h0
`define PFT_SEL_PTR_HIGH 3'h1
`define PFT_SEL_PTR_UPPER 3'h2
`define PFT_SEL_LATCH 3'h3
`define PFT_SEL_CONTROL 3'h4
`define PFT_SEL_UNLOCK 3'h5

// Control register bit positions
`define PFT_CTL_SPACE 7
`define PFT_CTL_CONFIG 6
`define PFT_CTL_ERASE 4
`define PFT_CTL_ABORT 3
`define PFT_CTL_UNLOCK_EN 2
`define PFT_CTL_GO 1

// Reset values
`define PFT_HOLD_RESET 8'hFF
`define PFT_PTR_RESET 22'h00_0000
`define PFT_CTL_RESET 8'h00

// Unlock keys
`define PFT_KEY_FIRST 8'h55
`define PFT_KEY_SECOND 8'hAA

// Geometry
`define PFT_PTR_W 22
`define PFT_BLOCK_BYTES 64
`define PFT_BLK_ADDR_W 16

// Self-timed long write
`define PFT_CLK_MHZ 200
`define PFT_PROG_TIME_US 2000
`define PFT_PROG_CYCLES (`PFT_PROG_TIME_US * `PFT_CLK_MHZ)
`define PFT_TIMER_W 24

`endif

//--- verilog/pft_pkg.sv
// Purpose: Types of the program flash table access block
// Assumes: pft_defines.svh supplies the pointer, block address and timer widths
// Notes: None
`default_nettype none
`include "pft_defines.svh"

package pft_pkg;

    typedef enum logic [1:0] {
        PFT_PTR_KEEP = 2'h0,
        PFT_PTR_POST_INC = 2'h1,
        PFT_PTR_POST_DEC = 2'h2,
        PFT_PTR_PRE_INC = 2'h3
    } pft_ptr_mode_t;

    typedef enum logic [3:0] {
        PFT_ST_IDLE = 4'h1,
        PFT_ST_KEY1 = 4'h2,
        PFT_ST_KEY2 = 4'h4,
        PFT_ST_BUSY = 4'h8
    } pft_state_t;

    // Table instruction request from the core
    typedef struct packed {
        logic req;
        logic write;
        pft_ptr_mode_t mode;
    } pft_tbl_req_t;

    // Special register access from the core
    typedef struct packed {
        logic wr;
        logic rd;
        logic [2:0] sel;
        logic [7:0] wdata;
    } pft_sfr_req_t;

    // Command towards the flash array
    typedef struct packed {
        logic rd_en;
        logic [20:0] rd_word_addr;
        logic erase;
        logic prog;
        logic [`PFT_BLK_ADDR_W-1:0] blk_addr;
    } pft_flash_cmd_t;

    typedef struct packed {
        pft_state_t fsm;
        logic [`PFT_PTR_W-1:0] ptr;
        logic [7:0] latch;
        logic space_sel;
        logic config_sel;
        logic erase_en;
        logic abort;
        logic unlock_en;
        logic go;
        logic done_flag;
        logic [`PFT_TIMER_W-1:0] timer;
        logic rd_wait;
        logic rd_byte_hi;
        logic hold_clr;
        logic [7:0] rdata;
        pft_flash_cmd_t flash;
    } pft_top_state_t;

endpackage

`default_nettype wire

//--- verilog/pft_hold_block.sv
// Purpose: Write block holding registers filled by table writes
// Assumes: Index is the in-block byte address of the table pointer
// Notes: Bytes left erased are masked out of programming
`default_nettype none
`include "pft_defines.svh"

module pft_hold_block #(
    parameter int BLOCK_BYTES = `PFT_BLOCK_BYTES
) (
    input wire logic i_ref_clk, // Core clock
    input wire logic i_arst_n, // Async reset, active low
    input wire logic i_wr, // Table write strobe
    input wire logic [$clog2(BLOCK_BYTES)-1:0] i_idx, // Byte index in block
    input wire logic [7:0] i_data, // Byte from table latch
    input wire logic i_clear, // Program done, return to erased
    output logic [BLOCK_BYTES*8-1:0] o_data, // Whole block, byte 0 lowest
    output logic [BLOCK_BYTES-1:0] o_byte_en // Byte differs from erased value
);

    typedef struct packed {
        logic [BLOCK_BYTES-1:0][7:0] hold;
    } pft_hold_state_t;

    pft_hold_state_t state_ff;
    pft_hold_state_t nxt_state;

    always_comb begin
        nxt_state = state_ff;
        if (i_clear) begin
            for (int i = 0; i < BLOCK_BYTES; i++) begin
                nxt_state.hold[i] = `PFT_HOLD_RESET;
            end
        end else if (i_wr) begin
            nxt_state.hold[i_idx] = i_data;
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            for (int i = 0; i < BLOCK_BYTES; i++) begin
                state_ff.hold[i] <= `PFT_HOLD_RESET;
            end
        end else begin
            state_ff <= nxt_state;
        end
    end

    assign o_data = state_ff.hold;

    genvar g;
    generate
        for (g = 0; g < BLOCK_BYTES; g++) begin : g_en
            assign o_byte_en[g] = (state_ff.hold[g] != `PFT_HOLD_RESET);
        end
    endgenerate

endmodule

`default_nettype wire

//--- verilog/pft_table_access.sv
// Purpose: Table pointer, table latch, guarded block erase and program of flash
// Assumes: Core drives one table or register request per cycle, synchronous
// Notes: Flash word must stand in the cycle of the read enable
`default_nettype none
`include "pft_defines.svh"

module pft_table_access #(
    parameter int PROG_CYCLES = `PFT_PROG_CYCLES, // Long write length in clocks
    parameter int BLOCK_BYTES = `PFT_BLOCK_BYTES // Write and erase block size
) (
    input wire logic i_ref_clk, // Core clock, 200 MHz
    input wire logic i_arst_n, // Async reset, active low
    input wire pft_pkg::pft_sfr_req_t i_sfr, // Register access
    output logic [7:0] o_sfr_rdata, // Read data, one cycle after rd
    input wire pft_pkg::pft_tbl_req_t i_tbl, // Table read or write request
    output logic o_tbl_busy, // Table read still in flight
    output logic o_cpu_stall, // Execution halted by long write
    output logic o_nvm_done_flag, // Long write completed, sticky
    input wire logic i_done_flag_clr, // Clear done flag
    output pft_pkg::pft_flash_cmd_t o_flash, // Command to flash array
    input wire logic [15:0] i_flash_rd_data, // Read word from flash array
    output logic [BLOCK_BYTES*8-1:0] o_flash_wdata, // Holding block data
    output logic [BLOCK_BYTES-1:0] o_flash_byte_en // Bytes to program
);
    import pft_pkg::*;

    localparam int IDX_W = $clog2(BLOCK_BYTES);

    pft_top_state_t state_ff;
    pft_top_state_t nxt_state;
    logic [`PFT_PTR_W-1:0] eff_addr;
    logic [`PFT_PTR_W-1:0] upd_ptr;
    logic tbl_go;
    logic hold_wr;
    logic ctl_wr;
    logic key_wr;
    logic start_ok;
    logic timer_done;

    // Low 21 bits step, top bit kept
    function automatic logic [`PFT_PTR_W-1:0] step_ptr(input logic [`PFT_PTR_W-1:0] p,
                                                        input logic up);
        logic [20:0] low;
        low = up ? (p[20:0] + 21'h0_0001) : (p[20:0] - 21'h0_0001);
        return {p[21], low};
    endfunction

    assign tbl_go = i_tbl.req && !state_ff.rd_wait && (state_ff.fsm != PFT_ST_BUSY);
    assign hold_wr = tbl_go && i_tbl.write;
    assign ctl_wr = i_sfr.wr && (i_sfr.sel == `PFT_SEL_CONTROL);
    assign key_wr = i_sfr.wr && (i_sfr.sel == `PFT_SEL_UNLOCK);
    assign timer_done = (state_ff.timer == `PFT_TIMER_W'(PROG_CYCLES - 1));
    assign start_ok = (state_ff.fsm == PFT_ST_KEY2) && ctl_wr && i_sfr.wdata[`PFT_CTL_GO]
        && i_sfr.wdata[`PFT_CTL_UNLOCK_EN] && i_sfr.wdata[`PFT_CTL_SPACE]
        && !i_sfr.wdata[`PFT_CTL_CONFIG];

    // Effective address and pointer after the access
    always_comb begin
        eff_addr = state_ff.ptr;
        upd_ptr = state_ff.ptr;
        case (i_tbl.mode)
            PFT_PTR_KEEP: begin
                upd_ptr = state_ff.ptr;
            end
            PFT_PTR_POST_INC: begin
                upd_ptr = step_ptr(state_ff.ptr, 1'b1);
            end
            PFT_PTR_POST_DEC: begin
                upd_ptr = step_ptr(state_ff.ptr, 1'b0);
            end
            PFT_PTR_PRE_INC: begin
                eff_addr = step_ptr(state_ff.ptr, 1'b1);
                upd_ptr = eff_addr;
            end
            default: begin
                upd_ptr = state_ff.ptr;
            end
        endcase
    end

    always_comb begin
        nxt_state = state_ff;
        nxt_state.flash.rd_en = 1'b0;
        nxt_state.flash.erase = 1'b0;
        nxt_state.flash.prog = 1'b0;
        nxt_state.hold_clr = 1'b0;

        // Table read: word address from bits 21..1, byte picked by bit 0
        if (state_ff.rd_wait) begin
            nxt_state.rd_wait = 1'b0;
            nxt_state.latch = state_ff.rd_byte_hi ? i_flash_rd_data[15:8]
                                                  : i_flash_rd_data[7:0];
        end
        if (tbl_go) begin
            nxt_state.ptr = upd_ptr;
            if (!i_tbl.write) begin
                nxt_state.flash.rd_en = 1'b1;
                nxt_state.flash.rd_word_addr = eff_addr[21:1];
                nxt_state.rd_byte_hi = eff_addr[0];
                nxt_state.rd_wait = 1'b1;
            end
        end

        // Register writes, blocked while the core is stalled
        if (i_sfr.wr && state_ff.fsm != PFT_ST_BUSY) begin
            case (i_sfr.sel)
                `PFT_SEL_PTR_LOW: nxt_state.ptr[7:0] = i_sfr.wdata;
                `PFT_SEL_PTR_HIGH: nxt_state.ptr[15:8] = i_sfr.wdata;
                `PFT_SEL_PTR_UPPER: nxt_state.ptr[21:16] = i_sfr.wdata[5:0];
                `PFT_SEL_LATCH: nxt_state.latch = i_sfr.wdata;
                `PFT_SEL_CONTROL: begin
                    nxt_state.space_sel = i_sfr.wdata[`PFT_CTL_SPACE];
                    nxt_state.config_sel = i_sfr.wdata[`PFT_CTL_CONFIG];
                    nxt_state.erase_en = i_sfr.wdata[`PFT_CTL_ERASE];
                    nxt_state.abort = i_sfr.wdata[`PFT_CTL_ABORT];
                    nxt_state.unlock_en = i_sfr.wdata[`PFT_CTL_UNLOCK_EN];
                    if (i_sfr.wdata[`PFT_CTL_GO] && !start_ok) begin
                        nxt_state.abort = 1'b1; // Improper start attempt
                    end
                end
                default: begin
                    nxt_state.rdata = state_ff.rdata;
                end
            endcase
        end

        // Unlock sequence and long write
        case (state_ff.fsm)
            PFT_ST_IDLE, PFT_ST_KEY1, PFT_ST_KEY2: begin
                if (start_ok) begin
                    nxt_state.fsm = PFT_ST_BUSY;
                    nxt_state.go = 1'b1;
                    nxt_state.abort = 1'b1;
                    nxt_state.timer = '0;
                    // Erase takes bits 21..6, program the same block, low bits ignored
                    nxt_state.flash.blk_addr = state_ff.ptr[21:6];
                end else if (key_wr && i_sfr.wdata == `PFT_KEY_FIRST) begin
                    nxt_state.fsm = PFT_ST_KEY1;
                end else if (key_wr && i_sfr.wdata == `PFT_KEY_SECOND
                             && state_ff.fsm == PFT_ST_KEY1) begin
                    nxt_state.fsm = PFT_ST_KEY2;
                end else if (i_sfr.wr || tbl_go) begin
                    nxt_state.fsm = PFT_ST_IDLE;
                end
            end
            PFT_ST_BUSY: begin
                nxt_state.timer = state_ff.timer + `PFT_TIMER_W'(1);
                if (state_ff.timer == '0) begin
                    nxt_state.flash.erase = state_ff.erase_en;
                    nxt_state.flash.prog = !state_ff.erase_en;
                end
                if (timer_done) begin
                    nxt_state.fsm = PFT_ST_IDLE;
                    nxt_state.go = 1'b0;
                    nxt_state.abort = 1'b0;
                    nxt_state.erase_en = 1'b0;
                    nxt_state.hold_clr = !state_ff.erase_en;
                    nxt_state.done_flag = 1'b1;
                end
            end
            default: begin
                nxt_state.fsm = PFT_ST_IDLE;
            end
        endcase

        // Done flag: set wins over clear
        if (i_done_flag_clr && !(state_ff.fsm == PFT_ST_BUSY && timer_done)) begin
            nxt_state.done_flag = 1'b0;
        end

        // Registered read data
        if (i_sfr.rd) begin
            case (i_sfr.sel)
                `PFT_SEL_PTR_LOW: nxt_state.rdata = state_ff.ptr[7:0];
                `PFT_SEL_PTR_HIGH: nxt_state.rdata = state_ff.ptr[15:8];
                `PFT_SEL_PTR_UPPER: nxt_state.rdata = {2'h0, state_ff.ptr[21:16]};
                `PFT_SEL_LATCH: nxt_state.rdata = state_ff.latch;
                `PFT_SEL_CONTROL: nxt_state.rdata = {state_ff.space_sel, state_ff.config_sel,
                    1'b0, state_ff.erase_en, state_ff.abort, state_ff.unlock_en,
                    state_ff.go, 1'b0};
                `PFT_SEL_UNLOCK: nxt_state.rdata = 8'h00;
                default: nxt_state.rdata = 8'h00;
            endcase
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            state_ff.fsm <= PFT_ST_IDLE;
            state_ff.ptr <= `PFT_PTR_RESET;
            state_ff.latch <= 8'h00;
            state_ff.space_sel <= 1'b0;
            state_ff.config_sel <= 1'b0;
            state_ff.erase_en <= 1'b0;
            state_ff.abort <= 1'b0;
            state_ff.unlock_en <= 1'b0;
            state_ff.go <= 1'b0;
            state_ff.done_flag <= 1'b0;
            state_ff.timer <= '0;
            state_ff.rd_wait <= 1'b0;
            state_ff.rd_byte_hi <= 1'b0;
            state_ff.hold_clr <= 1'b0;
            state_ff.rdata <= 8'h00;
            state_ff.flash <= '0;
        end else begin
            state_ff <= nxt_state;
        end
    end

    pft_hold_block #(
        .BLOCK_BYTES(BLOCK_BYTES)
    ) u_hold (
        .i_ref_clk(i_ref_clk),
        .i_arst_n(i_arst_n),
        .i_wr(hold_wr),
        .i_idx(eff_addr[IDX_W-1:0]),
        .i_data(state_ff.latch),
        .i_clear(state_ff.hold_clr),
        .o_data(o_flash_wdata),
        .o_byte_en(o_flash_byte_en)
    );

    assign o_sfr_rdata = state_ff.rdata;
    assign o_tbl_busy = state_ff.rd_wait;
    assign o_cpu_stall = (state_ff.fsm == PFT_ST_BUSY);
    assign o_nvm_done_flag = state_ff.done_flag;
    assign o_flash = state_ff.flash;

endmodule

`default_nettype wire

//--- sim/pft_table_access_props.sv
// Purpose: Port checker for the table access block
// Assumes: One clock domain
// Notes: Bound to every instance
`default_nettype none
`include "pft_defines.svh"
module pft_table_access_props #(
    parameter int PROG_CYCLES = 20,
    parameter int BLOCK_BYTES = 64
) (
    input wire logic i_ref_clk, // Clock
    input wire logic i_arst_n, // Reset
    input wire pft_pkg::pft_sfr_req_t i_sfr, // Reg access
    input wire logic [7:0] o_sfr_rdata, // Reg data
    input wire pft_pkg::pft_tbl_req_t i_tbl, // Table op
    input wire logic o_tbl_busy, // Read busy
    input wire logic o_cpu_stall, // Stall
    input wire logic o_nvm_done_flag, // Done
    input wire logic i_done_flag_clr, // Done clear
    input wire pft_pkg::pft_flash_cmd_t o_flash, // Flash cmd
    input wire logic [15:0] i_flash_rd_data, // Flash word
    input wire logic [BLOCK_BYTES*8-1:0] o_flash_wdata, // Holding
    input wire logic [BLOCK_BYTES-1:0] o_flash_byte_en // Byte mask
);
    import pft_pkg::*;
    logic [31:0] stall_cnt_ff;
    logic prog_seen_ff;
    logic mask_ok;
    always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            stall_cnt_ff <= 32'h0000_0000;
            prog_seen_ff <= 1'b0;
        end else begin
            stall_cnt_ff <= o_cpu_stall ? stall_cnt_ff + 32'h0000_0001 : 32'h0000_0000;
            prog_seen_ff <= o_flash.prog | (prog_seen_ff & ~o_flash.erase);
        end
    end
    always_comb begin
        mask_ok = 1'b1;
        for (int i = 0; i < BLOCK_BYTES; i++) begin
            if (o_flash_byte_en[i] != (o_flash_wdata[8*i+:8] != 8'hFF)) begin
                mask_ok = 1'b0;
            end
        end
    end
    default clocking cb @(posedge i_ref_clk);
    endclocking
    default disable iff (!i_arst_n);
    a_read_fetch: assert property (i_tbl.req && !i_tbl.write && !o_tbl_busy && !o_cpu_stall
        |=> o_flash.rd_en && o_tbl_busy) else $error("table read not fetched");
    a_start_guard: assert property ($rose(o_cpu_stall) |->
        $past(i_sfr.wr && i_sfr.sel == `PFT_SEL_CONTROL && i_sfr.wdata[`PFT_CTL_GO])
        && $past(i_sfr.wdata == `PFT_KEY_SECOND, 2) ##1 (o_flash.prog != o_flash.erase))
        else $error("bad long write start");
    a_stall_length: assert property ($fell(o_cpu_stall) |-> stall_cnt_ff == PROG_CYCLES)
        else $error("stall length wrong");
    a_done_set: assert property ($fell(o_cpu_stall) |-> o_nvm_done_flag)
        else $error("done flag not set");
    a_done_sticky: assert property (o_nvm_done_flag && !i_done_flag_clr |=> o_nvm_done_flag)
        else $error("done flag lost");
    a_done_clear: assert property (i_done_flag_clr && !o_cpu_stall |=> !o_nvm_done_flag)
        else $error("done flag not cleared");
    a_unlock_zero: assert property (i_sfr.rd && i_sfr.sel == `PFT_SEL_UNLOCK
        |=> o_sfr_rdata == 8'h00) else $error("unlock reads nonzero");
    a_byte_mask: assert property (mask_ok) else $error("byte mask mismatch");
    a_hold_cleared: assert property ($fell(o_cpu_stall) && prog_seen_ff
        |-> ##[1:2] (&o_flash_wdata)) else $error("holding not erased");
    a_stall_no_read: assert property (o_cpu_stall && i_tbl.req |=> !o_flash.rd_en)
        else $error("read during stall");
endmodule
bind pft_table_access pft_table_access_props #(.PROG_CYCLES(PROG_CYCLES),
    .BLOCK_BYTES(BLOCK_BYTES)) u_props (.i_ref_clk(i_ref_clk), .i_arst_n(i_arst_n),
    .i_sfr(i_sfr), .o_sfr_rdata(o_sfr_rdata), .i_tbl(i_tbl), .o_tbl_busy(o_tbl_busy),
    .o_cpu_stall(o_cpu_stall), .o_nvm_done_flag(o_nvm_done_flag),
    .i_done_flag_clr(i_done_flag_clr), .o_flash(o_flash), .i_flash_rd_data(i_flash_rd_data),
    .o_flash_wdata(o_flash_wdata), .o_flash_byte_en(o_flash_byte_en));
`default_nettype wire

//--- sim/pft_flash_model.sv
// Purpose: Flash array read model
// Assumes: Word stands while the read enable is high
// Notes: Word outside a read toggles every cycle
`default_nettype none
module pft_flash_model (
    input wire logic i_ref_clk, // Clock
    input wire logic i_arst_n, // Reset
    input wire pft_pkg::pft_flash_cmd_t i_cmd, // Command
    output logic [15:0] o_rd_data // Read word
);
    import pft_pkg::*;
    logic [15:0] idle_ff;
    always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            idle_ff <= 16'h0000;
        end else begin
            idle_ff <= ~idle_ff;
        end
    end
    // Block latches the word at the end of the read enable cycle
    assign o_rd_data = i_cmd.rd_en ? (i_cmd.rd_word_addr[15:0] ^ 16'h5A3C
        ^ {11'h000, i_cmd.rd_word_addr[20:16]}) : idle_ff;
endmodule
`default_nettype wire

//--- sim/pft_table_access_bench.sv
// Purpose: Self-checking bench of the table access block
// Assumes: Bench acts as the core
// Notes: Long write shortened to 20 clocks
`default_nettype none
`include "pft_defines.svh"
module pft_table_access_bench;
    timeunit 1ns;
    timeprecision 1ps;
    import pft_pkg::*;
    localparam int PROG = 20;
    logic i_ref_clk = 1'b0;
    logic i_arst_n = 1'b0;
    pft_sfr_req_t i_sfr = '0;
    pft_tbl_req_t i_tbl = '0;
    logic i_done_flag_clr = 1'b0;
    logic [7:0] rdata;
    logic busy, stall, done, last_erase;
    pft_flash_cmd_t fcmd;
    logic [15:0] fdata, last_blk;
    logic [511:0] wdata;
    logic [63:0] ben;
    int fails = 0;
    int num_checks = 0;
    int n_start = 0;
    int n_stall = 0;
    pft_ptr_mode_t mode_tab[4] = '{PFT_PTR_POST_INC, PFT_PTR_POST_DEC, PFT_PTR_PRE_INC,
        PFT_PTR_KEEP};
    always #2.5 i_ref_clk = ~i_ref_clk;
    pft_table_access #(.PROG_CYCLES(PROG), .BLOCK_BYTES(64)) u_dut (.i_ref_clk(i_ref_clk),
        .i_arst_n(i_arst_n), .i_sfr(i_sfr), .o_sfr_rdata(rdata), .i_tbl(i_tbl),
        .o_tbl_busy(busy), .o_cpu_stall(stall), .o_nvm_done_flag(done),
        .i_done_flag_clr(i_done_flag_clr), .o_flash(fcmd), .i_flash_rd_data(fdata),
        .o_flash_wdata(wdata), .o_flash_byte_en(ben));
    pft_flash_model u_flash (.i_ref_clk(i_ref_clk), .i_arst_n(i_arst_n), .i_cmd(fcmd),
        .o_rd_data(fdata));
    always @(posedge i_ref_clk) begin
        if (stall === 1'b1) begin
            n_stall++;
        end
        if (fcmd.prog || fcmd.erase) begin
            n_start++;
            last_blk = fcmd.blk_addr;
            last_erase = fcmd.erase;
        end
    end
    task automatic test_done();
        if (fails == 0 && num_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            fails++;
            $display("Error %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic idle();
        @(posedge i_ref_clk);
        i_sfr <= '0;
        i_tbl <= '0;
        i_done_flag_clr <= 1'b0;
    endtask
    task automatic sfr_wr(input logic [2:0] sel, input logic [7:0] d);
        @(posedge i_ref_clk);
        i_sfr <= {1'b1, 1'b0, sel, d};
    endtask
    task automatic sfr_rd(input logic [2:0] sel, input logic [7:0] exp, input string name);
        @(posedge i_ref_clk);
        i_sfr <= {1'b0, 1'b1, sel, 8'h00};
        idle();
        #1 chk(name, exp, rdata);
    endtask
    task automatic set_ptr(input logic [21:0] p);
        sfr_wr(`PFT_SEL_PTR_LOW, p[7:0]);
        sfr_wr(`PFT_SEL_PTR_HIGH, p[15:8]);
        sfr_wr(`PFT_SEL_PTR_UPPER, {2'b00, p[21:16]});
        idle();
    endtask
    task automatic chk_ptr(input logic [21:0] p);
        sfr_rd(`PFT_SEL_PTR_LOW, p[7:0], "ptr_low");
        sfr_rd(`PFT_SEL_PTR_HIGH, p[15:8], "ptr_high");
        sfr_rd(`PFT_SEL_PTR_UPPER, {2'b00, p[21:16]}, "ptr_upper");
    endtask
    task automatic tbl_op(input logic w, input pft_ptr_mode_t m);
        @(posedge i_ref_clk);
        i_sfr <= '0;
        i_tbl <= {1'b1, w, m};
        idle();
    endtask
    task automatic fill(input logic [7:0] d, input pft_ptr_mode_t m);
        sfr_wr(`PFT_SEL_LATCH, d);
        tbl_op(1'b1, m);
    endtask
    task automatic long_write(input logic [7:0] ctl);
        int n;
        sfr_wr(`PFT_SEL_UNLOCK, `PFT_KEY_FIRST);
        sfr_wr(`PFT_SEL_UNLOCK, `PFT_KEY_SECOND);
        sfr_wr(`PFT_SEL_CONTROL, ctl);
        tbl_op(1'b0, PFT_PTR_KEEP);
        n = 0;
        while (stall === 1'b1 && n < 200) begin
            @(posedge i_ref_clk);
            n++;
        end
        repeat (2) @(posedge i_ref_clk);
        #1;
    endtask
    task automatic test_reset();
        sfr_rd(`PFT_SEL_CONTROL, 8'h00, "control");
        sfr_rd(`PFT_SEL_UNLOCK, 8'h00, "unlock");
        chk_ptr(22'h00_0000);
        chk("hold_ff", 1, &wdata);
    endtask
    task automatic test_modes();
        logic [21:0] p, nx, eff;
        logic [15:0] w;
        pft_ptr_mode_t m;
        p = 22'h3F_FFFF;
        set_ptr(p);
        foreach (mode_tab[i]) begin
            m = mode_tab[i];
            nx = {p[21], (m == PFT_PTR_POST_DEC) ? p[20:0] - 21'h1 :
                (m == PFT_PTR_KEEP) ? p[20:0] : p[20:0] + 21'h1};
            eff = (m == PFT_PTR_PRE_INC) ? nx : p;
            w = eff[16:1] ^ 16'h5A3C ^ {11'h000, eff[21:17]};
            tbl_op(1'b0, m);
            #1 chk("rd_word_addr", eff[21:1], fcmd.rd_word_addr);
            chk("rd_en", 1, fcmd.rd_en);
            chk("tbl_busy", 1, busy);
            sfr_rd(`PFT_SEL_LATCH, eff[0] ? w[15:8] : w[7:0], "latch");
            chk_ptr(nx);
            p = nx;
        end
    endtask
    task automatic test_program();
        int n0;
        int s0;
        n0 = n_start;
        s0 = n_stall;
        set_ptr(22'h01_2F3E);
        fill(8'h12, PFT_PTR_POST_INC);
        fill(8'h34, PFT_PTR_POST_INC);
        fill(8'hFF, PFT_PTR_KEEP);
        #1 chk("byte_en_hi", 32'hC000_0000, ben[63:32]);
        chk("byte_en_lo", 0, ben[31:0]);
        chk("hold_top", 32'h0000_3412, wdata[511:496]);
        sfr_wr(`PFT_SEL_PTR_LOW, 8'h55);
        sfr_wr(`PFT_SEL_CONTROL, 8'h84);
        long_write(8'h86);
        chk("starts", n0 + 1, n_start);
        chk("stall_len", PROG, n_stall - s0);
        chk("prog_kind", 0, last_erase);
        chk("prog_blk", 32'h0000_04BD, last_blk);
        chk("done", 1, done);
        chk("hold_ff", 1, &wdata);
        sfr_rd(`PFT_SEL_CONTROL, 8'h84, "control");
        @(posedge i_ref_clk);
        i_done_flag_clr <= 1'b1;
        idle();
        #1 chk("done_clr", 0, done);
    endtask
    task automatic test_erase();
        set_ptr(22'h1A_5C7B);
        sfr_wr(`PFT_SEL_CONTROL, 8'h94);
        long_write(8'h96);
        chk("erase_kind", 1, last_erase);
        chk("erase_blk", 32'h0000_6971, last_blk);
        sfr_rd(`PFT_SEL_CONTROL, 8'h84, "control");
    endtask
    task automatic test_refuse();
        int n0;
        int s0;
        n0 = n_start;
        s0 = n_stall;
        sfr_wr(`PFT_SEL_UNLOCK, `PFT_KEY_FIRST);
        sfr_wr(`PFT_SEL_PTR_LOW, 8'h00);
        sfr_wr(`PFT_SEL_UNLOCK, `PFT_KEY_SECOND);
        sfr_wr(`PFT_SEL_CONTROL, 8'h86);
        idle();
        repeat (3) @(posedge i_ref_clk);
        chk("no_start", n0, n_start);
        sfr_rd(`PFT_SEL_CONTROL, 8'h8C, "control");
        sfr_wr(`PFT_SEL_CONTROL, 8'h80);
        long_write(8'h82);
        chk("no_start", n0, n_start);
        sfr_rd(`PFT_SEL_CONTROL, 8'h88, "control");
        long_write(8'hC6);
        chk("no_start", n0, n_start);
        sfr_rd(`PFT_SEL_CONTROL, 8'hCC, "control");
        chk("no_stall", s0, n_stall);
    endtask
    initial begin
        #20000;
        fails++;
        test_done();
    end
    initial begin
        repeat (3) @(posedge i_ref_clk);
        i_arst_n <= 1'b1;
        test_reset();
        test_modes();
        test_program();
        test_erase();
        test_refuse();
        test_done();
    end
endmodule
`default_nettype wire
